/* hw/umcl_pkg.sv */
// constants for the handshake, line and modem status block
`default_nettype none
package umcl_pkg;
  // ************************************************************
  // register offsets and widths
  // ************************************************************
  localparam logic [2:0] ADDR_HOC = 3'h4; // handshake_output_control
  localparam logic [2:0] ADDR_LCF = 3'h5; // line_condition_flags
  localparam logic [2:0] ADDR_HIF = 3'h6; // handshake_input_flags
  localparam int         DW       = 8;
  localparam logic [7:0] HOC_RST  = 8'h00;
  localparam logic [7:0] HOC_MASK = 8'h9f; // bits 5 and 6 read zero
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int HOC_DTR  = 0;
  localparam int HOC_RTS  = 1;
  localparam int HOC_AUXA = 2;
  localparam int HOC_AUXB = 3;
  localparam int HOC_LOOP = 4;
  localparam int HOC_OSC  = 7;
  localparam int IE_RX    = 0;
  localparam int IE_TX_HOLDING_EMPTY  = 1;
  localparam int IE_LINE  = 2;
  localparam int IE_MDM   = 3;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ  = 25_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD_HZ; // rounds down
  localparam int RX_W    = 11;                // data, parity, stop, break
  // ************************************************************
  // state encodings
  // ************************************************************
  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA  = 6'b000100,
    RX_PAR   = 6'b001000,
    RX_STOP  = 6'b010000,
    RX_HIGH  = 6'b100000
  } umcl_rx_t;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } umcl_tx_t;
endpackage
`default_nettype wire

/* hw/umcl_top.sv */
// handshake control, line status and modem status logic of a serial port
`default_nettype none
module umcl_top
  import umcl_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC,
  parameter bit PROCESSOR_RESET_OUTPUT_VAR   = 1'b0,
  parameter bit SMALL_PKG  = 1'b0
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic [2:0]    addr_i,
  input  wire logic          cs_i,
  input  wire logic          rd_i,
  input  wire logic          wr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic [3:0]    ier_i,
  input  wire logic          enh_mode_i,
  input  wire logic          fifo_mode_i,
  input  wire logic          parity_en_i,
  input  wire logic          parity_even_i,
  input  wire logic          set_break_i,
  input  wire logic [7:0]    tx_data_i,
  input  wire logic          tx_valid_i,
  output logic               tx_ready_o,
  output logic [7:0]         rx_data_o,
  output logic               rx_valid_o,
  input  wire logic          rx_ready_i,
  input  wire logic          serial_rx_pin_i,
  output logic               serial_tx_pin_o,
  input  wire logic          cts_n_i,
  input  wire logic          dsr_n_i,
  input  wire logic          ri_n_i,
  input  wire logic          dcd_n_i,
  output logic               dtr_n_o,
  output logic               rts_n_o,
  output logic               aux_output_a_n_o,
  output logic               aux_output_b_n_o,
  output logic               processor_reset_output_o,
  output logic               interrupt_pin_o,
  output logic               interrupt_pin_oe_o,
  output logic               osc_enable_o
);
  localparam logic [15:0] BITC = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // order: rx, dcd, ri, dsr, cts; idle level is high
  logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [4:0] agree;
  assign agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= 5'h1f;
      s2_reg  <= 5'h1f;
      s3_reg  <= 5'h1f;
      pin_reg <= 5'h1f;
    end else if (ce_i) begin
      s1_reg  <= {serial_rx_pin_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= (pin_reg & ~agree) | (s3_reg & agree); // glitch filter
    end
  end

  // ************************************************************
  // handshake outputs and modem status sources
  // ************************************************************
  logic [7:0] hoc_reg;
  logic       loop;
  logic [3:0] act;        // dcd, ri, dsr, cts as active-high
  logic       tx_line_reg;
  logic       rx_in;
  assign loop = hoc_reg[HOC_LOOP];
  assign dtr_n_o          = loop | ~hoc_reg[HOC_DTR];
  assign rts_n_o          = loop | ~hoc_reg[HOC_RTS];
  assign aux_output_a_n_o = loop | ~hoc_reg[HOC_AUXA];
  assign aux_output_b_n_o = loop | ~hoc_reg[HOC_AUXB];
  // reset output only exists on that variant; held low otherwise
  assign processor_reset_output_o = PROCESSOR_RESET_OUTPUT_VAR & hoc_reg[HOC_AUXA];
  assign osc_enable_o = ~(enh_mode_i & hoc_reg[HOC_OSC]);
  // loopback reroutes status from control bits
  assign act = loop ? {hoc_reg[HOC_AUXB], hoc_reg[HOC_AUXA], hoc_reg[HOC_DTR],
                       hoc_reg[HOC_RTS]} : ~pin_reg[3:0];
  assign serial_tx_pin_o = loop | (tx_line_reg & ~set_break_i);
  assign rx_in = loop ? tx_line_reg : pin_reg[4];

  // ************************************************************
  // receive fifo storage (shared by both modes)
  // ************************************************************
  logic [RX_W-1:0] rxm_reg [2];
  logic [RX_W-1:0] rxm_next [2];
  logic            rrp_reg, rrp_next;
  logic [1:0]      rcnt_reg, rcnt_next;
  logic            rx_push;
  logic [RX_W-1:0] rx_word;
  logic            rx_full, rx_pop;
  assign rx_full    = fifo_mode_i ? (rcnt_reg == 2'd2) : (rcnt_reg != 2'd0);
  assign rx_valid_o = (rcnt_reg != 2'd0);
  assign rx_data_o  = rxm_reg[rrp_reg][7:0];
  assign rx_pop     = rx_valid_o & rx_ready_i;

  // ************************************************************
  // receiver state machine
  // ************************************************************
  umcl_rx_t    rst_reg, rst_next;
  logic [15:0] rc_reg, rc_next;
  logic [2:0]  rb_reg, rb_next;
  logic [7:0]  rd_reg, rdn;
  logic        rz_reg, rz_next;   // every sample so far was zero
  logic        rpe_reg, rpe_next;
  logic        rtick;
  assign rtick = (rc_reg == 16'h0000);
  always_comb begin
    rst_next = rst_reg;
    rc_next  = rtick ? 16'h0000 : rc_reg - 16'h0001;
    rb_next  = rb_reg;
    rdn      = rd_reg;
    rz_next  = rz_reg;
    rpe_next = rpe_reg;
    rx_push  = 1'b0;
    rx_word  = '0;
    case (rst_reg)
      RX_IDLE: begin
        if (!rx_in) begin
          rst_next = RX_START;
          rc_next  = HALF;
        end
      end
      RX_START: begin
        if (rtick) begin
          rst_next = rx_in ? RX_IDLE : RX_DATA; // false start rejected
          rc_next  = BITC;
          rb_next  = 3'd0;
          rz_next  = 1'b1;
          rpe_next = 1'b0;
        end
      end
      RX_DATA: begin
        if (rtick) begin
          rdn     = {rx_in, rd_reg[7:1]};
          rz_next = rz_reg & ~rx_in;
          rc_next = BITC;
          rb_next = rb_reg + 3'd1;
          if (rb_reg == 3'd7) begin
            rst_next = parity_en_i ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rtick) begin
          rpe_next = rx_in != (parity_even_i ? ^rd_reg : ~^rd_reg);
          rz_next  = rz_reg & ~rx_in;
          rc_next  = BITC;
          rst_next = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rtick) begin
          rx_push = 1'b1;
          rc_next = BITC;
          if (rx_in) begin
            rx_word  = {1'b0, 1'b0, rpe_reg, rd_reg};
            rst_next = RX_IDLE;
          end else if (rz_reg) begin
            // line low for a whole character: one zero entry
            rx_word  = {1'b1, 1'b0, 1'b0, 8'h00};
            rst_next = RX_HIGH;
          end else begin
            // bad stop taken as next start bit, go straight to data
            rx_word  = {1'b0, 1'b1, rpe_reg, rd_reg};
            rst_next = RX_DATA;
            rb_next  = 3'd0;
            rz_next  = 1'b1;
            rpe_next = 1'b0;
          end
        end
      end
      RX_HIGH: begin
        if (rx_in) begin
          rst_next = RX_IDLE;
        end
      end
      default: rst_next = RX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_reg <= RX_IDLE;
      rc_reg  <= 16'h0000;
      rb_reg  <= 3'd0;
      rd_reg  <= 8'h00;
      rz_reg  <= 1'b0;
      rpe_reg <= 1'b0;
    end else if (ce_i) begin
      rst_reg <= rst_next;
      rc_reg  <= rc_next;
      rb_reg  <= rb_next;
      rd_reg  <= rdn;
      rz_reg  <= rz_next;
      rpe_reg <= rpe_next;
    end
  end

  // ************************************************************
  // transmit buffer and shifter
  // ************************************************************
  logic [7:0] txm_reg [2];
  logic [7:0] txm_next [2];
  logic       twp_reg, twp_next, trp_reg, trp_next;
  logic [1:0] tcnt_reg, tcnt_next;
  umcl_tx_t   tst_reg, tst_next;
  logic [15:0] tc_reg, tc_next;
  logic [2:0] tb_reg, tb_next;
  logic [7:0] ts_reg, ts_next;
  logic       tl_next, tpar_reg, tpar_next;
  logic       tx_push, tx_load, tx_holding_empty, tx_all_empty;
  assign tx_ready_o = fifo_mode_i ? (tcnt_reg != 2'd2) : (tcnt_reg == 2'd0);
  assign tx_push    = tx_valid_i & tx_ready_o;
  assign tx_load    = (tst_reg == TX_IDLE) & (tcnt_reg != 2'd0);
  // trigger level is one entry, so empty below it
  assign tx_holding_empty = (tcnt_reg == 2'd0);
  assign tx_all_empty = tx_holding_empty & (tst_reg == TX_IDLE);
  always_comb begin
    txm_next  = txm_reg;
    twp_next  = twp_reg;
    trp_next  = trp_reg;
    tcnt_next = tcnt_reg;
    tst_next  = tst_reg;
    tc_next   = (tc_reg == 16'h0000) ? 16'h0000 : tc_reg - 16'h0001;
    tb_next   = tb_reg;
    ts_next   = ts_reg;
    tl_next   = tx_line_reg;
    tpar_next = tpar_reg;
    if (tx_push) begin
      txm_next[twp_reg] = tx_data_i; // holding write clears the empty flag
      twp_next          = ~twp_reg;
    end
    if (tx_load) begin
      trp_next = ~trp_reg;
    end
    tcnt_next = tcnt_reg + {1'b0, tx_push} - {1'b0, tx_load};
    case (tst_reg)
      TX_IDLE: begin
        if (tx_load) begin
          ts_next   = txm_reg[trp_reg];
          tpar_next = parity_even_i ? ^txm_reg[trp_reg] : ~^txm_reg[trp_reg];
          tl_next   = 1'b0;
          tc_next   = BITC;
          tst_next  = TX_START;
        end
      end
      TX_START: begin
        if (tc_reg == 16'h0000) begin
          tl_next  = ts_reg[0];
          tb_next  = 3'd0;
          tc_next  = BITC;
          tst_next = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tc_reg == 16'h0000) begin
          tc_next = BITC;
          tb_next = tb_reg + 3'd1;
          ts_next = {1'b0, ts_reg[7:1]};
          if (tb_reg == 3'd7) begin
            tl_next  = parity_en_i ? tpar_reg : 1'b1;
            tst_next = parity_en_i ? TX_PAR : TX_STOP;
          end else begin
            tl_next = ts_reg[1];
          end
        end
      end
      TX_PAR: begin
        if (tc_reg == 16'h0000) begin
          tl_next  = 1'b1;
          tc_next  = BITC;
          tst_next = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tc_reg == 16'h0000) begin
          tst_next = TX_IDLE;
        end
      end
      default: tst_next = TX_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txm_reg     <= '{default: 8'h00};
      twp_reg     <= 1'b0;
      trp_reg     <= 1'b0;
      tcnt_reg    <= 2'd0;
      tst_reg     <= TX_IDLE;
      tc_reg      <= 16'h0000;
      tb_reg      <= 3'd0;
      ts_reg      <= 8'h00;
      tx_line_reg <= 1'b1;
      tpar_reg    <= 1'b0;
    end else if (ce_i) begin
      txm_reg     <= txm_next;
      twp_reg     <= twp_next;
      trp_reg     <= trp_next;
      tcnt_reg    <= tcnt_next;
      tst_reg     <= tst_next;
      tc_reg      <= tc_next;
      tb_reg      <= tb_next;
      ts_reg      <= ts_next;
      tx_line_reg <= tl_next;
      tpar_reg    <= tpar_next;
    end
  end

  // ************************************************************
  // registers, sticky flags and receive fifo update
  // ************************************************************
  logic [3:0] err_reg, err_next;   // break, frame, parity, overrun
  logic [3:0] dlt_reg, dlt_next;   // dcd change, ring going active, dsr change, cts change
  logic [3:0] act_reg;
  logic [7:0] rdata_next, hoc_next, lcf, hif;
  logic       rd_lcf, rd_hif, rx_ok, head_new, fifo_err;
  logic [RX_W-1:0] head_w;
  assign rd_lcf = cs_i & rd_i & (addr_i == ADDR_LCF);
  assign rd_hif = cs_i & rd_i & (addr_i == ADDR_HIF);
  assign rx_ok  = rx_push & ~rx_full;
  // errors of stored entries, in fifo mode only; bit 7 drops once none remain
  assign fifo_err = fifo_mode_i & (
    ((rcnt_reg != 2'd0) & (|rxm_reg[rrp_reg][10:8])) |
    ((rcnt_reg == 2'd2) & (|rxm_reg[~rrp_reg][10:8])));
  assign lcf = {fifo_err, tx_all_empty, tx_holding_empty, err_reg, rx_valid_o};
  assign hif = {act, dlt_reg};
  // an entry becomes head: empty fill, or pop exposing the next
  assign head_new = (rx_ok & ((rcnt_reg == 2'd0) | (rx_pop & (rcnt_reg == 2'd1))))
                  | (rx_pop & (rcnt_reg == 2'd2));
  assign head_w = (rx_pop & (rcnt_reg == 2'd2)) ? rxm_reg[~rrp_reg] : rx_word;
  always_comb begin
    hoc_next   = hoc_reg;
    rdata_next = rdata_o;
    rxm_next   = rxm_reg;
    rrp_next   = rrp_reg;
    rcnt_next  = rcnt_reg + {1'b0, rx_ok} - {1'b0, rx_pop};
    err_next   = rd_lcf ? 4'h0 : err_reg;
    dlt_next   = rd_hif ? 4'h0 : dlt_reg;
    if (cs_i & wr_i & (addr_i == ADDR_HOC)) begin
      hoc_next = wdata_i & HOC_MASK;
    end
    if (cs_i & rd_i) begin
      case (addr_i)
        ADDR_HOC: rdata_next = hoc_reg;
        ADDR_LCF: rdata_next = lcf;
        ADDR_HIF: rdata_next = hif;
        default:  rdata_next = 8'h00; // other offsets live elsewhere
      endcase
    end
    if (rx_ok) begin
      rxm_next[rrp_reg ^ (rcnt_reg != 2'd0)] = rx_word;
    end
    if (rx_pop) begin
      rrp_next = ~rrp_reg;
    end
    // setting beats the read clear in the same cycle
    if (rx_push & rx_full) begin
      err_next[0] = 1'b1;
    end
    if (head_new) begin
      err_next[3:1] = err_next[3:1] | head_w[10:8];
    end
    dlt_next[0] = dlt_next[0] | (act[0] ^ act_reg[0]);
    dlt_next[1] = dlt_next[1] | (act[1] ^ act_reg[1]);
    dlt_next[2] = dlt_next[2] | (act[2] & ~act_reg[2]);
    dlt_next[3] = dlt_next[3] | (act[3] ^ act_reg[3]);
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hoc_reg  <= HOC_RST;
      rdata_o  <= 8'h00;
      rxm_reg  <= '{default: '0};
      rrp_reg  <= 1'b0;
      rcnt_reg <= 2'd0;
      err_reg  <= 4'h0;
      dlt_reg  <= 4'h0;
      act_reg  <= 4'h0;
    end else if (ce_i) begin
      hoc_reg  <= hoc_next;
      rdata_o  <= rdata_next;
      rxm_reg  <= rxm_next;
      rrp_reg  <= rrp_next;
      rcnt_reg <= rcnt_next;
      err_reg  <= err_next;
      dlt_reg  <= dlt_next;
      act_reg  <= act;
    end
  end

  // ************************************************************
  // interrupt request pin
  // ************************************************************
  // enables come from the separate enable register, also in loopback
  assign interrupt_pin_o = (ier_i[IE_LINE] & (|err_reg))
                         | (ier_i[IE_TX_HOLDING_EMPTY] & tx_holding_empty)
                         | (ier_i[IE_MDM] & (|dlt_reg))
                         | (ier_i[IE_RX] & rx_valid_o);
  assign interrupt_pin_oe_o = SMALL_PKG ? hoc_reg[HOC_AUXB] : 1'b1;
endmodule
`default_nettype wire

/* tb/umcl_properties.sv */
// concurrent checks on the ports of the handshake block
`default_nettype none
module umcl_properties
  import umcl_pkg::*;
#(
  parameter bit PROCESSOR_RESET_OUTPUT_VAR  = 1'b0,
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire logic          ce_i,
  input wire logic [2:0]    addr_i,
  input wire logic          cs_i,
  input wire logic          rd_i,
  input wire logic          wr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          enh_mode_i,
  input wire logic          serial_tx_pin_o,
  input wire logic          dtr_n_o,
  input wire logic          rts_n_o,
  input wire logic          aux_output_a_n_o,
  input wire logic          aux_output_b_n_o,
  input wire logic          processor_reset_output_o,
  input wire logic          osc_enable_o
);
  logic [7:0] hoc_reg;
  logic [7:0] hoc_next;
  logic [7:0] hoc_m;
  // shadow of the control register, fed by the same write strobe
  assign hoc_m = hoc_reg & HOC_MASK;
  always_comb begin
    hoc_next = hoc_reg;
    if (ce_i && cs_i && wr_i && addr_i == ADDR_HOC) begin
      hoc_next = wdata_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hoc_reg <= HOC_RST;
    end else begin
      hoc_reg <= hoc_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // loopback forces dtr, rts and both aux outputs inactive; the reset output still follows aux a
  property p_dtr; dtr_n_o == (hoc_reg[HOC_LOOP] | !hoc_reg[HOC_DTR]); endproperty
  a_dtr: assert property (p_dtr) else $error("ready output wrong");
  property p_rts; rts_n_o == (hoc_reg[HOC_LOOP] | !hoc_reg[HOC_RTS]); endproperty
  a_rts: assert property (p_rts) else $error("request output wrong");
  property p_auxa; aux_output_a_n_o == (hoc_reg[HOC_LOOP] | !hoc_reg[HOC_AUXA]); endproperty
  a_auxa: assert property (p_auxa) else $error("aux a output wrong");
  property p_auxb; aux_output_b_n_o == (hoc_reg[HOC_LOOP] | !hoc_reg[HOC_AUXB]); endproperty
  a_auxb: assert property (p_auxb) else $error("aux b output wrong");
  property p_processor_reset_output; processor_reset_output_o == (PROCESSOR_RESET_OUTPUT_VAR & hoc_reg[HOC_AUXA]); endproperty
  a_processor_reset_output: assert property (p_processor_reset_output) else $error("reset output wrong");
  property p_loop_tx; hoc_reg[HOC_LOOP] |-> serial_tx_pin_o; endproperty
  a_loop_tx: assert property (p_loop_tx) else $error("serial out low in loop");
  property p_osc; osc_enable_o == !(enh_mode_i & hoc_reg[HOC_OSC]); endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  // a read answers one cycle later with bits 5 and 6 forced low
  property p_rd_hoc;
    ce_i && cs_i && rd_i && addr_i == ADDR_HOC |=> rdata_o == $past(hoc_m);
  endproperty
  a_rd_hoc: assert property (p_rd_hoc) else $error("control readback wrong");
endmodule
bind umcl_top umcl_properties #(.PROCESSOR_RESET_OUTPUT_VAR(PROCESSOR_RESET_OUTPUT_VAR), .SMALL_PKG(SMALL_PKG)) umcl_properties_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .cs_i(cs_i), .rd_i(rd_i),
  .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .enh_mode_i(enh_mode_i),
  .serial_tx_pin_o(serial_tx_pin_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
  .aux_output_a_n_o(aux_output_a_n_o), .aux_output_b_n_o(aux_output_b_n_o),
  .processor_reset_output_o(processor_reset_output_o), .osc_enable_o(osc_enable_o)
);
`default_nettype wire

/* tb/umcl_line_model.sv */
// modem and serial line model at the far side of the block
`default_nettype none
module umcl_line_model #(
  parameter int BIT_NS = 640
) (
  input  wire logic clk_i,
  input  wire logic serial_tx_pin_i,
  output var  logic serial_rx_pin_o,
  output var  logic cts_n_o,
  output var  logic dsr_n_o,
  output var  logic ri_n_o,
  output var  logic dcd_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line is at mark, handshake inputs inactive
  initial begin
    serial_rx_pin_o = 1'b1;
    {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = 4'hf;
  end
  task automatic mdm(input logic [3:0] v);
    {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = v;
  endtask
  // start, data lsb first, parity, stop; back to mark afterwards
  task automatic send(input logic [7:0] d, input logic par, input logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    @(posedge clk_i) #1;
    for (int i = 0; i < 11; i++) begin
      serial_rx_pin_o = f[i];
      #(BIT_NS);
    end
    serial_rx_pin_o = 1'b1;
  endtask
  task automatic hold_low(input int n);
    @(posedge clk_i) #1;
    serial_rx_pin_o = 1'b0;
    #(BIT_NS * n);
    serial_rx_pin_o = 1'b1;
  endtask
  // samples mid bit, offset from the edge to avoid a race
  task automatic recv(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 2000 && !ok; i++) begin
      @(posedge clk_i);
      ok = !serial_tx_pin_i;
    end
    #(BIT_NS * 3 / 2 + 3);
    for (int i = 0; i < 8; i++) begin
      d[i] = serial_tx_pin_i;
      #(BIT_NS);
    end
  endtask
endmodule
`default_nettype wire

/* tb/umcl_top_tb.sv */
// self-checking bench for the handshake, line and modem status block
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module umcl_top_tb
  import umcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 16; // short bit time keeps the run brief
  int n_checks = 0;
  int failures = 0;
  logic clk_i = 0, rst_n_i = 0, cs_i = 0, rd_i = 0, wr_i = 0, enh_mode_i = 0;
  logic tx_valid_i = 0, rx_ready_i = 0;
  logic ce_i = 1, fifo_mode_i = 0, parity_en_i = 1, parity_even_i = 1, set_break_i = 0;
  logic [2:0] addr_i = 3'h0;
  logic [3:0] ier_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, tx_data_i = 8'h00, rdata_o, rx_data_o;
  logic tx_ready_o, rx_valid_o, rxd, txd, cts_n, dsr_n, ri_n, dcd_n;
  logic dtr_n_o, rts_n_o, aux_a_n, aux_b_n, irq, osc_en;
  umcl_top #(.BIT_CYCLES(BC)) umcl_top_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .cs_i(cs_i),
    .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ier_i(ier_i),
    .enh_mode_i(enh_mode_i), .fifo_mode_i(fifo_mode_i), .parity_en_i(parity_en_i),
    .parity_even_i(parity_even_i), .set_break_i(set_break_i), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .serial_rx_pin_i(rxd), .serial_tx_pin_o(txd), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
    .ri_n_i(ri_n), .dcd_n_i(dcd_n), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
    .aux_output_a_n_o(aux_a_n), .aux_output_b_n_o(aux_b_n), .processor_reset_output_o(),
    .interrupt_pin_o(irq), .interrupt_pin_oe_o(), .osc_enable_o(osc_en));
  umcl_line_model #(.BIT_NS(BC * 40)) umcl_line_model_i (
    .clk_i(clk_i), .serial_tx_pin_i(txd), .serial_rx_pin_o(rxd), .cts_n_o(cts_n),
    .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n));
  always #20 clk_i = ~clk_i;
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one register access; strobes held across exactly one taking edge
  task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i) #1;
    {cs_i, rd_i, wr_i, addr_i, wdata_i} = {1'b1, !w, w, a, d};
    @(posedge clk_i) #1;
    {cs_i, rd_i, wr_i} = 3'h0;
    q = rdata_o;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    bus(a, 1'b0, 8'h00, q);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic settle();
    repeat (10) @(posedge clk_i);
  endtask
  task automatic pop(output logic [7:0] d);
    int n;
    n = 0;
    while (rx_valid_o !== 1'b1 && n < 400) begin
      @(posedge clk_i) #1;
      n++;
    end
    if (n == 400) begin
      failures++;
      tally_and_finish();
    end
    d = rx_data_o;
    rx_ready_i = 1'b1;
    @(posedge clk_i) #1;
    rx_ready_i = 1'b0;
  endtask
  task automatic send_tx(input logic [7:0] d);
    int n;
    n = 0;
    {tx_data_i, tx_valid_i} = {d, 1'b1};
    while (tx_ready_o !== 1'b1 && n < 400) begin
      @(posedge clk_i) #1;
      n++;
    end
    @(posedge clk_i) #1;
    tx_valid_i = 1'b0;
  endtask
  // empties the receive side, then clears the sticky flags
  task automatic drain();
    logic [7:0] q;
    rx_ready_i = 1'b1;
    repeat (33 * BC) @(posedge clk_i);
    #1 rx_ready_i = 1'b0;
    rd(ADDR_LCF, q);
    rd(ADDR_HIF, q);
  endtask
  task automatic chk_hif(input logic [7:0] e);
    logic [7:0] q;
    settle();
    rd(ADDR_HIF, q);
    `CHK(q, e)
  endtask
  task automatic t_control();
    logic [7:0] q;
    rd(ADDR_HOC, q);
    `CHK(q, HOC_RST)
    for (int v = 0; v < 16; v++) begin
      wr(ADDR_HOC, 8'(v));
      `CHK({aux_b_n, aux_a_n, rts_n_o, dtr_n_o}, ~4'(v))
    end
    wr(ADDR_HOC, 8'hff);
    rd(ADDR_HOC, q);
    `CHK(q, HOC_MASK)
    `CHK(osc_en, 1'b1)
    enh_mode_i = 1'b1;
    #1 `CHK(osc_en, 1'b0)
    enh_mode_i = 1'b0;
    wr(ADDR_HOC, 8'h00);
    settle();
    // a write while the enable is low must not land
    ce_i = 1'b0;
    wr(ADDR_HOC, 8'h03);
    ce_i = 1'b1;
    rd(ADDR_HOC, q);
    `CHK(q, HOC_RST)
  endtask
  task automatic t_modem();
    logic [7:0] q;
    ier_i = 4'h8;
    rd(ADDR_HIF, q);
    umcl_line_model_i.mdm(4'he);
    settle();
    `CHK(irq, 1'b1)
    chk_hif(8'h11);
    `CHK(irq, 1'b0)
    chk_hif(8'h10);
    umcl_line_model_i.mdm(4'ha);
    chk_hif(8'h54);
    umcl_line_model_i.mdm(4'he);
    chk_hif(8'h10);
    umcl_line_model_i.mdm(4'h0);
    chk_hif(8'hfe);
    umcl_line_model_i.mdm(4'hf);
    drain();
  endtask
  task automatic t_loop();
    logic [7:0] q;
    wr(ADDR_HOC, 8'h1b);
    umcl_line_model_i.serial_rx_pin_o = 1'b0;
    umcl_line_model_i.mdm(4'h0);
    settle();
    `CHK({dtr_n_o, rts_n_o, aux_a_n, aux_b_n}, 4'hf)
    rd(ADDR_HIF, q);
    `CHK(q[7:4], 4'hb)
    send_tx(8'h5a);
    pop(q);
    `CHK(q, 8'h5a)
    umcl_line_model_i.serial_rx_pin_o = 1'b1;
    umcl_line_model_i.mdm(4'hf);
    wr(ADDR_HOC, 8'h00);
    drain();
  endtask
  // good character, parity fault, then overrun with a held entry
  task automatic t_rx();
    logic [7:0] q;
    ier_i = 4'h4;
    umcl_line_model_i.send(8'ha5, ^8'ha5, 1'b1);
    settle();
    rd(ADDR_LCF, q);
    `CHK(q, 8'h61)
    pop(q);
    `CHK(q, 8'ha5)
    rd(ADDR_LCF, q);
    `CHK(q, 8'h60)
    umcl_line_model_i.send(8'h3c, ~^8'h3c, 1'b1);
    settle();
    `CHK(irq, 1'b1)
    rd(ADDR_LCF, q);
    `CHK(q, 8'h65)
    rd(ADDR_LCF, q);
    `CHK(q, 8'h61)
    `CHK(irq, 1'b0)
    for (int i = 1; i < 4; i++) begin
      umcl_line_model_i.send(8'(i * 3), ^8'(i * 3), 1'b1);
    end
    settle();
    rd(ADDR_LCF, q);
    `CHK(q[1], 1'b1)
    pop(q);
    `CHK(q, 8'h3c)
    drain();
  endtask
  task automatic t_break();
    logic [7:0] q;
    umcl_line_model_i.hold_low(12);
    settle();
    rd(ADDR_LCF, q);
    `CHK(q[4], 1'b1)
    pop(q);
    `CHK(q, 8'h00)
    settle();
    `CHK(rx_valid_o, 1'b0)
    drain();
  endtask
  task automatic t_tx();
    logic [7:0] q;
    logic [7:0] v;
    logic ok;
    ier_i = 4'h2;
    #1 `CHK(irq, 1'b1)
    fork
      umcl_line_model_i.recv(q, ok);
      begin
        send_tx(8'hc3);
        rd(ADDR_LCF, v);
        `CHK(v[6], 1'b0)
      end
    join
    `CHK({ok, q}, {1'b1, 8'hc3})
    repeat (4) settle();
    rd(ADDR_LCF, v);
    `CHK(v[6:5], 2'b11)
    // clean break: zero pad, then break once the transmitter is idle
    send_tx(8'h00);
    repeat (20) settle();
    rd(ADDR_LCF, v);
    `CHK(v[6], 1'b1)
    set_break_i = 1'b1;
    #1 `CHK(txd, 1'b0)
    set_break_i = 1'b0;
    #1 `CHK(txd, 1'b1)
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_control();
    t_modem();
    t_loop();
    t_rx();
    t_break();
    t_tx();
    tally_and_finish();
  end
endmodule
`default_nettype wire
